// ===== rtl/mem_fmt_pkg.sv
package mem_fmt_pkg;
  // avalon register word offsets (avs_address = 2 * index)
  localparam logic [3:0] system_control_reg_idx    = 4'h0;
  localparam logic [3:0] first_mode_reg_idx     = 4'h1;
  localparam logic [3:0] second_mode_reg_idx     = 4'h2;
  localparam logic [3:0] sticky_idx    = 4'h3;
  localparam logic [3:0] latch_idx     = 4'h4;
  localparam logic [3:0] mask_idx      = 4'h5;
  localparam logic [3:0] ivt_idx       = 4'h6;
  localparam logic [3:0] last_idx      = 4'h7;
  // field positions
  localparam int vti_bit       = 2;
  localparam int bws_lo        = 9;
  localparam int sse_bit       = 13;
  localparam int pe_en_bit     = 21;
  localparam int bc_second_bit = 22;
  localparam int bc_first_bit  = 23;
  localparam int iop_det_bit   = 20;
  localparam int mis_det_bit   = 21;
  localparam int stk_iop_bit   = 0;
  localparam int stk_mis_bit   = 1;
  localparam int irq_bit       = 0;
  // reset values and vector addresses
  localparam logic [31:0] reg_reset    = 32'h0000_0000;
  localparam logic [31:0] ivt_internal = 32'h0008_0000;
  localparam logic [31:0] ivt_noboot   = 32'h000a_0000;
  localparam logic [31:0] unmapped_rd  = 32'h0000_0000;

  // access size requested by the core
  typedef enum logic [1:0] {
    sz_short  = 2'h0,
    sz_normal = 2'h1,
    sz_long   = 2'h2,
    sz_instr  = 2'h3
  } word_size_t;

  // memory access width chosen
  typedef enum logic [3:0] {
    w16 = 4'b0001,
    w32 = 4'b0010,
    w48 = 4'b0100,
    w64 = 4'b1000
  } width_t;

  // one core access request
  typedef struct packed {
    logic        valid;
    logic        write;
    word_size_t  size;
    logic        force_long_word;
    logic        bus_exchange;
    logic        block_sel;
    logic        iop_target;
    logic        from_dma;
    logic        dag_second;
    logic [3:0]  reg_idx;
    logic [23:0] addr;
    logic [39:0] reg_lo;
    logic [39:0] reg_hi;
  } core_req_t;

  // formatted access toward memory and register file
  typedef struct packed {
    logic        valid;
    logic        write;
    width_t      width;
    logic [23:0] addr;
    logic [63:0] mem_wdata;
    logic [3:0]  reg_first;
    logic [3:0]  reg_second;
    logic        pair;
    logic        broadcast;
    logic        simd;
  } mem_acc_t;
endpackage

// ===== rtl/core_memory_access_formatter.sv
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module core_memory_access_formatter (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   boot_from_external,
  input  wire mem_fmt_pkg::core_req_t req,
  input  wire logic [63:0]            mem_rdata,
  output mem_fmt_pkg::mem_acc_t       acc,
  output logic [39:0]                 load_first,
  output logic [39:0]                 load_second,
  output logic                        illegal_input_interrupt,
  input  wire logic [4:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest
);
  logic [31:0] system_control_reg_q, first_mode_reg_q, second_mode_reg_q;
  logic [1:0]  sticky_q, latch_q, mask_q;
  logic        ack_q;
  logic [3:0]  widx;
  logic        wr_hit, rd_hit;
  logic [31:0] be_mask;
  mem_fmt_pkg::width_t w_d;
  logic        misaligned, iop_event;
  logic [23:0] eff_addr;
  logic [3:0]  even_reg;

  assign widx    = avs_address[4:1];
  assign wr_hit  = avs_write && !ack_q;
  assign rd_hit  = avs_read && !ack_q;
  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // one wait state: waitrequest drops the cycle after a request appears
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q           <= (avs_read || avs_write) && !ack_q;
      avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
    end
  end

  // control registers written on the accepting edge only
  always_ff @(posedge clk) begin
    if (rst) begin
      system_control_reg_q <= mem_fmt_pkg::reg_reset;
      first_mode_reg_q  <= mem_fmt_pkg::reg_reset;
      second_mode_reg_q  <= mem_fmt_pkg::reg_reset;
      mask_q   <= 2'h0;
    end else if (avs_write && ack_q) begin
      unique case (widx)
        mem_fmt_pkg::system_control_reg_idx:
          system_control_reg_q <= (system_control_reg_q & ~be_mask) | (avs_writedata & be_mask);
        mem_fmt_pkg::first_mode_reg_idx:
          first_mode_reg_q <= (first_mode_reg_q & ~be_mask) | (avs_writedata & be_mask);
        mem_fmt_pkg::second_mode_reg_idx:
          second_mode_reg_q <= (second_mode_reg_q & ~be_mask) | (avs_writedata & be_mask);
        mem_fmt_pkg::mask_idx:
          if (avs_byteenable[0]) mask_q <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // event detection; dma traffic never counts as an iop violation
  assign iop_event  = req.valid && req.iop_target && !req.from_dma
                      && second_mode_reg_q[mem_fmt_pkg::iop_det_bit];
  assign misaligned = req.valid && req.size == mem_fmt_pkg::sz_normal
                      && req.force_long_word && req.addr[0]
                      && second_mode_reg_q[mem_fmt_pkg::mis_det_bit];

  logic clr_sticky, clr_latch;
  assign clr_sticky = avs_write && ack_q && widx == mem_fmt_pkg::sticky_idx
                      && avs_byteenable[0];
  assign clr_latch  = avs_write && ack_q && widx == mem_fmt_pkg::latch_idx
                      && avs_byteenable[0];

  // sticky flags: write one to clear, a new event wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      sticky_q <= 2'h0;
      latch_q  <= 2'h0;
    end else begin
      sticky_q <= (sticky_q & ~(clr_sticky ? avs_writedata[1:0] : 2'h0))
                  | {misaligned, iop_event};
      latch_q  <= (latch_q & ~(clr_latch ? avs_writedata[1:0] : 2'h0))
                  | {1'b0, misaligned | iop_event};
    end
  end

  // interrupt is the latched condition gated by the mask
  always_ff @(posedge clk) begin
    if (rst) illegal_input_interrupt <= 1'b0;
    else illegal_input_interrupt <= |(latch_q & mask_q);
  end

  // width selection; forced long wins over simd and block width
  always_comb begin
    unique case (req.size)
      mem_fmt_pkg::sz_short: w_d = mem_fmt_pkg::w16;
      mem_fmt_pkg::sz_long:  w_d = mem_fmt_pkg::w64;
      mem_fmt_pkg::sz_instr: w_d = mem_fmt_pkg::w48;
      default: begin
        if (req.force_long_word) w_d = mem_fmt_pkg::w64;
        else if (req.bus_exchange) w_d = mem_fmt_pkg::w48;
        else if (system_control_reg_q[mem_fmt_pkg::bws_lo + 32'(req.block_sel)])
          w_d = mem_fmt_pkg::w48;
        else w_d = mem_fmt_pkg::w32;
      end
    endcase
  end

  // forced odd address drops to the even word below; long space is word aligned
  assign eff_addr = (req.size == mem_fmt_pkg::sz_normal && req.force_long_word)
                    ? {req.addr[23:1], 1'b0} : req.addr;
  assign even_reg = {req.reg_idx[3:1], 1'b0};

  // register the formatted access toward memory
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= '0;
    end else begin
      acc.valid      <= req.valid;
      acc.write      <= req.write;
      acc.width      <= w_d;
      acc.addr       <= eff_addr;
      acc.simd       <= first_mode_reg_q[mem_fmt_pkg::pe_en_bit]
                        && !(req.size == mem_fmt_pkg::sz_normal
                             && req.force_long_word);
      acc.broadcast  <= !req.write && (req.dag_second
                        ? first_mode_reg_q[mem_fmt_pkg::bc_second_bit]
                        : first_mode_reg_q[mem_fmt_pkg::bc_first_bit]);
      acc.pair       <= (w_d == mem_fmt_pkg::w64);
      acc.reg_first  <= (w_d == mem_fmt_pkg::w64) ? even_reg : req.reg_idx;
      acc.reg_second <= even_reg | 4'h1;
      unique case (w_d)
        mem_fmt_pkg::w16: acc.mem_wdata <= {48'h0, req.reg_lo[23:8]};
        mem_fmt_pkg::w32: acc.mem_wdata <= {32'h0, req.reg_lo[39:8]};
        mem_fmt_pkg::w48: acc.mem_wdata <= {16'h0, req.reg_lo, 8'h00};
        default:          acc.mem_wdata <= {req.reg_hi[39:8], req.reg_lo[39:8]};
      endcase
    end
  end

  // load formatting for the read data returned with the registered access
  always_ff @(posedge clk) begin
    if (rst) begin
      load_first  <= 40'h0;
      load_second <= 40'h0;
    end else begin
      unique case (acc.width)
        mem_fmt_pkg::w16: load_first <= {(first_mode_reg_q[mem_fmt_pkg::sse_bit]
                              ? {16{mem_rdata[15]}} : 16'h0), mem_rdata[15:0], 8'h00};
        mem_fmt_pkg::w32: load_first <= {mem_rdata[31:0], 8'h00};
        mem_fmt_pkg::w48: load_first <= mem_rdata[47:8];
        default:          load_first <= {mem_rdata[31:0], 8'h00};
      endcase
      load_second <= (acc.width == mem_fmt_pkg::w64)
                     ? {mem_rdata[63:32], 8'h00} : 40'h0;
    end
  end

  // read mux, registered on the request cycle so data stand with the ack
  always_ff @(posedge clk) begin
    if (rst) avs_readdata <= 32'h0;
    else if (rd_hit) begin
      unique case (widx)
        mem_fmt_pkg::system_control_reg_idx: avs_readdata <= system_control_reg_q;
        mem_fmt_pkg::first_mode_reg_idx:  avs_readdata <= first_mode_reg_q;
        mem_fmt_pkg::second_mode_reg_idx:  avs_readdata <= second_mode_reg_q;
        mem_fmt_pkg::sticky_idx: avs_readdata <= {30'h0, sticky_q};
        mem_fmt_pkg::latch_idx:  avs_readdata <= {30'h0, latch_q};
        mem_fmt_pkg::mask_idx:   avs_readdata <= {30'h0, mask_q};
        mem_fmt_pkg::ivt_idx:    avs_readdata <= (system_control_reg_q[mem_fmt_pkg::vti_bit]
                                   || boot_from_external)
                                   ? mem_fmt_pkg::ivt_internal
                                   : mem_fmt_pkg::ivt_noboot;
        default:                 avs_readdata <= mem_fmt_pkg::unmapped_rd;
      endcase
    end
  end

  // assertions share the core clock and sleep through reset
  default clocking cb_core @(posedge clk); endclocking
  default disable iff (rst);

  a_forced_long_width: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_normal && req.force_long_word
    |=> acc.width == mem_fmt_pkg::w64 && !acc.addr[0])
    else $error("forced long not 64-bit aligned");

  a_short_width: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_short
    |=> acc.width == mem_fmt_pkg::w16)
    else $error("short access width wrong");

  a_instr_width: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_instr
    |=> acc.width == mem_fmt_pkg::w48)
    else $error("instruction access width wrong");

  a_long_width: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_long
    |=> acc.width == mem_fmt_pkg::w64)
    else $error("long access width wrong");

  a_exchange_width: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_normal && !req.force_long_word
    && req.bus_exchange |=> acc.width == mem_fmt_pkg::w48)
    else $error("exchange access width wrong");

  a_narrow_width: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_normal && !req.force_long_word
    && !req.bus_exchange && !req.block_sel && !system_control_reg_q[mem_fmt_pkg::bws_lo]
    |=> acc.width == mem_fmt_pkg::w32)
    else $error("narrow block width wrong");

  a_wide_width: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_normal && !req.force_long_word
    && !req.bus_exchange && req.block_sel && system_control_reg_q[mem_fmt_pkg::bws_lo + 1]
    |=> acc.width == mem_fmt_pkg::w48)
    else $error("wide block width wrong");

  a_simd_forced_off: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_normal && req.force_long_word
    |=> !acc.simd)
    else $error("simd kept on forced long");

  a_simd_follows: assert property (
    req.valid && !req.force_long_word && first_mode_reg_q[mem_fmt_pkg::pe_en_bit]
    |=> acc.simd)
    else $error("simd not selected");

  // broadcast is a load-only feature
  a_bcast_store: assert property (
    acc.write |-> !acc.broadcast)
    else $error("broadcast on a store");

  a_bcast_first: assert property (
    req.valid && !req.write && !req.dag_second
    && first_mode_reg_q[mem_fmt_pkg::bc_first_bit] |=> acc.broadcast)
    else $error("first index broadcast missing");

  a_unforced_addr: assert property (
    req.valid && !(req.size == mem_fmt_pkg::sz_normal && req.force_long_word)
    |=> acc.addr == $past(req.addr))
    else $error("address altered");

  a_single_reg: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_normal && !req.force_long_word
    && req.bus_exchange |=> !acc.pair && acc.reg_first == $past(req.reg_idx))
    else $error("extended access not single register");

  a_long_pair: assert property (
    req.valid && req.size == mem_fmt_pkg::sz_long
    |=> acc.pair && acc.reg_first == {$past(req.reg_idx[3:1]), 1'b0})
    else $error("long access not paired");

  a_pair_even: assert property (
    acc.pair |-> !acc.reg_first[0] && acc.reg_second == (acc.reg_first | 4'h1))
    else $error("bad neighbour pair");

  // store formatting toward memory
  a_short_store: assert property (
    acc.valid && acc.write && acc.width == mem_fmt_pkg::w16
    |-> acc.mem_wdata[63:16] == 48'h0)
    else $error("short store upper lanes not zero");

  a_normal_store: assert property (
    acc.valid && acc.write && acc.width == mem_fmt_pkg::w32
    |-> acc.mem_wdata[63:32] == 32'h0)
    else $error("normal store upper half not zero");

  a_ext_store_zero: assert property (
    acc.valid && acc.write && acc.width == mem_fmt_pkg::w48
    |-> acc.mem_wdata[7:0] == 8'h00 && acc.mem_wdata[63:48] == 16'h0)
    else $error("extended store not zero filled");

  // load formatting toward the register file
  a_extended_zero: assert property (
    acc.valid && acc.width == mem_fmt_pkg::w32 |=> load_first[7:0] == 8'h00)
    else $error("low byte not zero");

  a_ext_load: assert property (
    acc.valid && !acc.write && acc.width == mem_fmt_pkg::w48
    |=> load_first == $past(mem_rdata[47:8]))
    else $error("extended load not truncated");

  a_short_low_zero: assert property (
    acc.valid && acc.width == mem_fmt_pkg::w16 |=> load_first[7:0] == 8'h00)
    else $error("short load low byte not zero");

  a_short_zero_fill: assert property (
    acc.valid && acc.width == mem_fmt_pkg::w16 && !first_mode_reg_q[mem_fmt_pkg::sse_bit]
    |=> load_first[39:24] == 16'h0)
    else $error("short load not zero filled");

  a_short_sign: assert property (
    acc.valid && acc.width == mem_fmt_pkg::w16 && first_mode_reg_q[mem_fmt_pkg::sse_bit]
    && mem_rdata[15] |=> load_first[39:24] == 16'hffff)
    else $error("short load not sign extended");

  a_long_load_hi: assert property (
    acc.valid && acc.width == mem_fmt_pkg::w64
    |=> load_second == {$past(mem_rdata[63:32]), 8'h00})
    else $error("upper long word misplaced");

  // detection, sticky flags and interrupt
  a_misalign_sticky: assert property (
    misaligned |=> sticky_q[mem_fmt_pkg::stk_mis_bit])
    else $error("misaligned flag not set");

  a_iop_sticky: assert property (
    req.valid && req.iop_target && !req.from_dma
    && second_mode_reg_q[mem_fmt_pkg::iop_det_bit] |=> sticky_q[mem_fmt_pkg::stk_iop_bit])
    else $error("iop flag not set");

  a_detect_off: assert property (
    !second_mode_reg_q[mem_fmt_pkg::mis_det_bit] && !second_mode_reg_q[mem_fmt_pkg::iop_det_bit]
    && sticky_q == 2'h0 |=> sticky_q == 2'h0)
    else $error("flag set while detection off");

  a_dma_no_flag: assert property (
    req.valid && req.from_dma && !misaligned && !sticky_q[0] && !clr_sticky
    |=> !sticky_q[mem_fmt_pkg::stk_iop_bit])
    else $error("dma raised iop flag");

  a_sticky_hold: assert property (
    sticky_q[mem_fmt_pkg::stk_mis_bit] && !clr_sticky
    |=> sticky_q[mem_fmt_pkg::stk_mis_bit])
    else $error("sticky flag lost");

  a_latch_set: assert property (
    misaligned |=> latch_q[0])
    else $error("misaligned not latched");

  a_irq_mask_gate: assert property (
    latch_q[0] && mask_q[0] |=> illegal_input_interrupt)
    else $error("interrupt not raised");

  a_irq_masked: assert property (
    !mask_q[0] |=> !illegal_input_interrupt)
    else $error("masked interrupt raised");

  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest stuck");

  // main scenarios worth seeing at least once
  c_forced_odd: cover property (misaligned);
  c_iop_event: cover property (iop_event ##2 illegal_input_interrupt);
  c_short_sign: cover property (acc.width == mem_fmt_pkg::w16 && mem_rdata[15]);
  c_long_pair: cover property (acc.valid && acc.pair);
  c_ext_access: cover property (acc.valid && acc.width == mem_fmt_pkg::w48);
endmodule // core_memory_access_formatter

// ===== test/sram_model.sv
`timescale 1ns/1ps
// behavioural internal memory block, answers in the cycle of the access
module sram_model (
  input  wire logic                  clk,
  input  wire mem_fmt_pkg::mem_acc_t acc,
  output logic [63:0]                mem_rdata
);
  logic [63:0] last_q = 64'h0;

  // outside a read the bus is released: show the inverse, never a stale copy
  always_comb begin
    if (acc.valid && !acc.write) begin
      mem_rdata = {8'ha5, acc.addr, 8'h5a, acc.addr};
    end else begin
      mem_rdata = ~last_q;
    end
  end

  // remember the last bus value so released cycles toggle
  always_ff @(posedge clk) begin
    last_q <= mem_rdata;
  end
endmodule // sram_model

// ===== test/core_memory_access_formatter_test.sv
`timescale 1ns/1ps
module core_memory_access_formatter_test;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   boot_ext = 1'b1;
  mem_fmt_pkg::core_req_t req = '0;
  mem_fmt_pkg::core_req_t r;
  mem_fmt_pkg::mem_acc_t  acc;
  mem_fmt_pkg::mem_acc_t  a;
  logic [63:0]            mem_rdata;
  logic [63:0]            p;
  logic [39:0]            load_first;
  logic [39:0]            load_second;
  logic [39:0]            l1;
  logic [39:0]            l2;
  logic                   irq;
  logic [4:0]             avs_address = 5'h00;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [31:0]            avs_readdata;
  logic [31:0]            rd;
  logic                   avs_waitrequest;
  int                     n_fail = 0;
  int                     total_checks = 0;

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  core_memory_access_formatter i_core_memory_access_formatter (
    .clk(clk), .rst(rst), .boot_from_external(boot_ext), .req(req),
    .mem_rdata(mem_rdata), .acc(acc), .load_first(load_first),
    .load_second(load_second), .illegal_input_interrupt(irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  sram_model i_sram_model (.clk(clk), .acc(acc), .mem_rdata(mem_rdata));

  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one avalon cycle; request held until waitrequest is sampled low
  task av(input logic wr, input logic [3:0] ix, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {ix, 1'b0};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      complete_run();
    end
  endtask

  task rdc(input logic [3:0] ix, input logic [31:0] e);
    av(1'b0, ix, 32'h0);
    chk($sformatf("reg %0d", ix), {32'h0, e}, {32'h0, rd});
  endtask

  function automatic mem_fmt_pkg::core_req_t mk(input mem_fmt_pkg::word_size_t s,
                                                 input logic f, input logic [23:0] ad);
    mk = '0;
    mk.valid = 1'b1;
    mk.size = s;
    mk.force_long_word = f;
    mk.addr = ad;
    mk.reg_idx = 4'h4;
    mk.reg_lo = 40'h1122334455;
  endfunction

  // one core access: acc a cycle later, register loads the cycle after
  task go(input mem_fmt_pkg::core_req_t q, input mem_fmt_pkg::width_t w);
    @(posedge clk);
    req <= q;
    @(posedge clk);
    req <= '0;
    #1 a = acc;
    p = {8'ha5, a.addr, 8'h5a, a.addr};
    @(posedge clk);
    #1 l1 = load_first;
    l2 = load_second;
    chk("width", {60'h0, w}, {60'h0, a.width});
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(mem_fmt_pkg::system_control_reg_idx, mem_fmt_pkg::reg_reset);
    rdc(mem_fmt_pkg::ivt_idx, mem_fmt_pkg::ivt_internal);
    boot_ext <= 1'b0;
    rdc(mem_fmt_pkg::ivt_idx, mem_fmt_pkg::ivt_noboot);
    av(1'b1, mem_fmt_pkg::system_control_reg_idx, 32'h0000_0004);
    rdc(mem_fmt_pkg::ivt_idx, mem_fmt_pkg::ivt_internal);
    av(1'b1, mem_fmt_pkg::last_idx, 32'hffff_ffff);
    rdc(mem_fmt_pkg::last_idx, mem_fmt_pkg::unmapped_rd);
    // widths and load formatting with both blocks at 32 bits
    go(mk(mem_fmt_pkg::sz_instr, 1'b0, 24'h000010), mem_fmt_pkg::w48);
    r = mk(mem_fmt_pkg::sz_normal, 1'b0, 24'h000020);
    r.bus_exchange = 1'b1;
    go(r, mem_fmt_pkg::w48);
    r.force_long_word = 1'b1;
    r.addr = 24'h000022;
    go(r, mem_fmt_pkg::w64);
    av(1'b1, mem_fmt_pkg::first_mode_reg_idx, 32'h0000_2000);
    go(mk(mem_fmt_pkg::sz_short, 1'b0, 24'h008123), mem_fmt_pkg::w16);
    chk("short sx", {24'h0, 16'hffff, a.addr[15:0], 8'h00}, {24'h0, l1});
    av(1'b1, mem_fmt_pkg::first_mode_reg_idx, 32'h0);
    go(mk(mem_fmt_pkg::sz_short, 1'b0, 24'h008123), mem_fmt_pkg::w16);
    chk("short zf", {24'h0, 16'h0000, a.addr[15:0], 8'h00}, {24'h0, l1});
    go(mk(mem_fmt_pkg::sz_normal, 1'b0, 24'h000031), mem_fmt_pkg::w32);
    chk("normal ld", {24'h0, p[31:0], 8'h00}, {24'h0, l1});
    r = mk(mem_fmt_pkg::sz_normal, 1'b0, 24'h000032);
    r.write = 1'b1;
    go(r, mem_fmt_pkg::w32);
    chk("normal st", 64'h11223344, {32'h0, a.mem_wdata[31:0]});
    // block 0 switched to three-column words, block 1 left at 32
    av(1'b1, mem_fmt_pkg::system_control_reg_idx, 32'h0000_0204);
    go(r, mem_fmt_pkg::w48);
    chk("ext st", {16'h0, 40'h1122334455, 8'h00}, {16'h0, a.mem_wdata[47:0]});
    go(mk(mem_fmt_pkg::sz_normal, 1'b0, 24'h000033), mem_fmt_pkg::w48);
    chk("ext ld", {24'h0, p[47:8]}, {24'h0, l1});
    r = mk(mem_fmt_pkg::sz_normal, 1'b0, 24'h000034);
    r.block_sel = 1'b1;
    go(r, mem_fmt_pkg::w32);
    // long words: unforced pairs low/high, forced odd drops to even
    r = mk(mem_fmt_pkg::sz_long, 1'b0, 24'h000021);
    r.reg_idx = 4'h6;
    go(r, mem_fmt_pkg::w64);
    chk("lpair", 64'hcf, {55'h0, a.reg_first, a.reg_second, a.pair});
    chk("lload lo", {24'h0, p[31:0], 8'h0}, {24'h0, l1});
    chk("lload hi", {24'h0, p[63:32], 8'h0}, {24'h0, l2});
    r.write = 1'b1;
    r.reg_hi = 40'haabbccddee;
    go(r, mem_fmt_pkg::w64);
    chk("lstore", 64'haabbccdd_11223344, a.mem_wdata);
    go(mk(mem_fmt_pkg::sz_normal, 1'b1, 24'h000013), mem_fmt_pkg::w64);
    chk("fpair", 64'h8b, {55'h0, a.reg_first, a.reg_second, a.pair});
    chk("faddr", 64'h12, {40'h0, a.addr});
    chk("fload lo", {24'h0, p[31:0], 8'h0}, {24'h0, l1});
    chk("fload hi", {24'h0, p[63:32], 8'h0}, {24'h0, l2});
    // simd and the two broadcast enables
    av(1'b1, mem_fmt_pkg::first_mode_reg_idx, 32'h0020_0000);
    go(mk(mem_fmt_pkg::sz_normal, 1'b1, 24'h000040), mem_fmt_pkg::w64);
    chk("simd off", 64'h0, {63'h0, a.simd});
    go(mk(mem_fmt_pkg::sz_normal, 1'b0, 24'h000041), mem_fmt_pkg::w48);
    chk("simd", 64'h1, {63'h0, a.simd});
    for (int i = 0; i < 4; i++) begin
      av(1'b1, mem_fmt_pkg::first_mode_reg_idx, i[1] ? 32'h0040_0000 : 32'h0080_0000);
      r = mk(mem_fmt_pkg::sz_normal, 1'b0, 24'h000050);
      r.dag_second = i[0];
      go(r, mem_fmt_pkg::w48);
      chk("bcast", {63'h0, i[1] == i[0]}, {63'h0, a.broadcast});
    end
    // detection disabled, then enabled; a dma iop access never latches
    go(mk(mem_fmt_pkg::sz_normal, 1'b1, 24'h000015), mem_fmt_pkg::w64);
    r = mk(mem_fmt_pkg::sz_normal, 1'b0, 24'h000060);
    r.iop_target = 1'b1;
    go(r, mem_fmt_pkg::w48);
    rdc(mem_fmt_pkg::sticky_idx, 32'h0);
    av(1'b1, mem_fmt_pkg::second_mode_reg_idx, 32'h0030_0000);
    r.from_dma = 1'b1;
    go(r, mem_fmt_pkg::w48);
    rdc(mem_fmt_pkg::latch_idx, 32'h0);
    r.from_dma = 1'b0;
    go(r, mem_fmt_pkg::w48);
    rdc(mem_fmt_pkg::sticky_idx, 32'h1);
    rdc(mem_fmt_pkg::latch_idx, 32'h1);
    av(1'b1, mem_fmt_pkg::latch_idx, 32'h1);
    go(mk(mem_fmt_pkg::sz_normal, 1'b1, 24'h000015), mem_fmt_pkg::w64);
    rdc(mem_fmt_pkg::sticky_idx, 32'h3);
    rdc(mem_fmt_pkg::latch_idx, 32'h1);
    chk("irq masked", 64'h0, {63'h0, irq});
    av(1'b1, mem_fmt_pkg::mask_idx, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq", 64'h1, {63'h0, irq});
    av(1'b1, mem_fmt_pkg::sticky_idx, 32'h3);
    av(1'b1, mem_fmt_pkg::latch_idx, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk("irq clr", 64'h0, {63'h0, irq});
    rdc(mem_fmt_pkg::sticky_idx, 32'h0);
    complete_run();
  end
endmodule // core_memory_access_formatter_test
